// *** cxe_core.sv ***
// execution core for branch-if-zero, call, clear, clear-watchdog, complement
// assumes an apb master and a data memory answering within one clock
//
// Contract
// - branch-if-zero branches only when zero flag is one, else falls through.
// - taken branch loads incremented counter plus twice the signed offset.
// - branch takes one cycle untaken, two taken; extra cycle idle.
// - call is two words: low eight target bits, then bits nineteen to eight.
// - call pushes counter plus four onto the return stack top.
// - shadow flag set copies work, flags and bank select to shadows.
// - shadow flag clear leaves the three shadow copies untouched.
// - call loads its 20-bit target into counter bits 20 to 1.
// - call takes two cycles; second cycle does nothing.
// - clear writes zero to the addressed location and sets zero flag.
// - access flag zero picks access bank; one uses bank select.
// - access zero with extended set uses indexed mode for f up to 95.
// - clear-watchdog zeroes counter and postscaler, sets timeout, powerdown.
// - complement inverts the register and updates negative and zero flags.
// - destination zero writes work register; one writes back the source.
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ns
module cxe_core (
  // clock and reset
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_rst,
  // apb slave
  input  wire logic                 i_psel,
  input  wire logic                 i_penable,
  input  wire logic                 i_pwrite,
  input  wire logic [7:0]           i_paddr,
  input  wire logic [31:0]          i_pwdata,
  output logic      [31:0]          o_prdata,
  output logic                      o_pready,
  output logic                      o_pslverr,
  // data memory
  output logic [cxe_pkg::DADDR_W-1:0] o_dmem_addr,
  output logic                      o_dmem_we,
  output logic [7:0]                o_dmem_wdata,
  input  wire logic [7:0]           i_dmem_rdata
);
  import cxe_pkg::*;

  cxe_state_t        st_q, st_d;
  logic              pend_q, pend_d;
  logic [15:0]       slot_q, slot_d;
  logic [15:0]       ir_q, ir_d;
  logic [PC_W-1:0]   pc_q, pc_d;
  logic [PC_W-1:0]   tos_q, tos_d;
  logic [7:0]        work_q, work_d;
  logic [STAT_W-1:0] flags_q, flags_d;
  logic [3:0]        bank_q, bank_d;
  logic [7:0]        work_shd_q, work_shd_d;
  logic [STAT_W-1:0] flags_shd_q, flags_shd_d;
  logic [3:0]        bank_shd_q, bank_shd_d;
  logic              ext_en_q, ext_en_d;
  logic [11:0]       index_q, index_d;
  logic [7:0]        opnd_q, opnd_d;
  logic [7:0]        res_q, res_d;
  logic              taken_q, taken_d;
  logic [7:0]        wdt_q, wdt_d;
  logic [7:0]        post_q, post_d;
  logic              to_n_q, to_n_d;
  logic              pd_n_q, pd_n_d;
  logic [DADDR_W-1:0] daddr_q, daddr_d;
  logic              dwe_q, dwe_d;
  logic [7:0]        dwdata_q, dwdata_d;
  logic [31:0]       prdata_q, prdata_d;
  logic              pready_q, pready_d;
  logic              pslverr_q, pslverr_d;

  cxe_phase_t        phase;
  logic              last;
  logic              run;
  logic              stall;
  logic [DADDR_W-1:0] faddr;
  logic              indexed;
  logic              is_bz, is_call, is_clear_file_op, is_complement_file_op, is_clear_watchdog_op;
  logic              wr_en, rd_en, hit, sw_ok;
  logic [31:0]       rd_mux;

  assign is_bz     = (ir_q[15:8] == OP_BZ);
  assign is_call   = (ir_q[15:9] == OP_CALL);
  assign is_clear_file_op   = (ir_q[15:9] == OP_CLEAR_FILE_OP);
  assign is_complement_file_op   = (ir_q[15:10] == OP_COMPLEMENT_FILE_OP);
  assign is_clear_watchdog_op = (ir_q == OP_CLEAR_WATCHDOG_OP);

  // the call waits in its fourth phase until the second word is written
  assign stall = (st_q == ST_EXEC) && is_call && (phase == PH_Q4) && !pend_q;
  assign run   = (st_q != ST_IDLE) && !stall;
  assign sw_ok = (st_q == ST_IDLE) && !pend_q;

  cxe_phase_gen u_phase (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_run     (run),
    .o_phase   (phase),
    .o_last    (last)
  );

  cxe_addr_dec u_addr (
    .i_use_bank   (ir_q[8]),
    .i_fsel       (ir_q[7:0]),
    .i_bank       (bank_q),
    .i_ext_en     (ext_en_q),
    .i_index_base (index_q),
    .o_addr       (faddr),
    .o_indexed    (indexed)
  );

  // apb decode: one wait state, read data and error registered
  assign rd_en = i_psel && i_penable && !pready_q;
  assign wr_en = i_psel && i_penable && pready_q && i_pwrite;

  always_comb begin
    rd_mux = 32'h00000000;
    hit    = 1'b1;
    case (i_paddr)
      REG_INSTR:  rd_mux[15:0] = ir_q;
      REG_CTRL:   rd_mux[CTRL_EXT_BIT] = ext_en_q;
      REG_PC:     rd_mux[PC_W-1:0] = pc_q;
      REG_WORK:   rd_mux[7:0] = work_q;
      REG_FLAGS:  rd_mux[STAT_W-1:0] = flags_q;
      REG_CORE: begin
        rd_mux[CORE_BUSY_BIT] = (st_q != ST_IDLE);
        rd_mux[CORE_PEND_BIT] = pend_q;
        rd_mux[CORE_TO_BIT]   = to_n_q;
        rd_mux[CORE_PD_BIT]   = pd_n_q;
      end
      REG_BANK:   rd_mux[3:0] = bank_q;
      REG_SHADOW: begin
        rd_mux[7:0] = work_shd_q;
        rd_mux[SHD_STAT_LSB +: STAT_W] = flags_shd_q;
        rd_mux[SHD_BANK_LSB +: 4] = bank_shd_q;
      end
      REG_STACK:  rd_mux[PC_W-1:0] = tos_q;
      REG_WDOG: begin
        rd_mux[7:0] = wdt_q;
        rd_mux[WDOG_POST_LSB +: 8] = post_q;
      end
      REG_INDEX:  rd_mux[11:0] = index_q;
      default:    hit = 1'b0;
    endcase
  end

  always_comb begin
    pready_d  = rd_en;
    prdata_d  = prdata_q;
    pslverr_d = 1'b0;
    if (rd_en) begin
      prdata_d  = i_pwrite ? 32'h00000000 : rd_mux;
      pslverr_d = !hit;
    end
  end

  always_comb begin
    st_d        = st_q;
    pend_d      = pend_q;
    slot_d      = slot_q;
    ir_d        = ir_q;
    pc_d        = pc_q;
    tos_d       = tos_q;
    work_d      = work_q;
    flags_d     = flags_q;
    bank_d      = bank_q;
    work_shd_d  = work_shd_q;
    flags_shd_d = flags_shd_q;
    bank_shd_d  = bank_shd_q;
    ext_en_d    = ext_en_q;
    index_d     = index_q;
    opnd_d      = opnd_q;
    res_d       = res_q;
    taken_d     = taken_q;
    daddr_d     = daddr_q;
    dwe_d       = dwe_q;
    dwdata_d    = dwdata_q;
    // free-running watchdog: postscaler wrap is the counter's enable
    post_d      = post_q + 8'h01;
    wdt_d       = (post_q == 8'hff) ? wdt_q + 8'h01 : wdt_q;
    to_n_d      = (post_q == 8'hff && wdt_q == 8'hff) ? 1'b0 : to_n_q;
    pd_n_d      = pd_n_q;

    // software writes to pc, work, flags, bank and index only while nothing is in flight
    if (wr_en) begin
      case (i_paddr)
        REG_INSTR: begin
          if (!pend_q) begin
            slot_d = i_pwdata[15:0];
            pend_d = 1'b1;
          end
        end
        REG_CTRL:  ext_en_d = i_pwdata[CTRL_EXT_BIT];
        REG_PC:    if (sw_ok) pc_d = {i_pwdata[PC_W-1:1], 1'b0};
        REG_WORK:  if (sw_ok) work_d = i_pwdata[7:0];
        REG_FLAGS: if (sw_ok) flags_d = i_pwdata[STAT_W-1:0];
        REG_BANK:  if (sw_ok) bank_d = i_pwdata[3:0];
        REG_INDEX: if (sw_ok) index_d = i_pwdata[11:0];
        default: ;
      endcase
    end

    case (st_q)
      ST_IDLE: begin
        if (pend_q) begin
          ir_d   = slot_q;
          pend_d = 1'b0;
          st_d   = ST_EXEC;
        end
      end
      ST_EXEC: begin
        case (phase)
          PH_Q1: begin
            pc_d    = pc_q + 21'h000002;
            daddr_d = faddr;
          end
          PH_Q2: begin
            opnd_d  = i_dmem_rdata;
            taken_d = flags_q[FLG_Z_BIT];
          end
          PH_Q3: begin
            res_d = is_clear_file_op ? 8'h00 : ~opnd_q;
            if (is_clear_file_op || (is_complement_file_op && ir_q[9])) begin
              dwe_d    = 1'b1;
              dwdata_d = is_clear_file_op ? 8'h00 : ~opnd_q;
            end
            if (is_call) begin
              tos_d = pc_q + 21'h000002;
              if (ir_q[8]) begin
                work_shd_d  = work_q;
                flags_shd_d = flags_q;
                bank_shd_d  = bank_q;
              end
            end
            if (is_clear_watchdog_op) begin
              wdt_d  = 8'h00;
              post_d = 8'h00;
              to_n_d = 1'b1;
              pd_n_d = 1'b1;
            end
          end
          PH_Q4: begin
            dwe_d = 1'b0;
            st_d  = ST_IDLE;
            if (is_clear_file_op) begin
              flags_d[FLG_Z_BIT] = 1'b1;
            end
            if (is_complement_file_op) begin
              flags_d[FLG_N_BIT] = res_q[7];
              flags_d[FLG_Z_BIT] = (res_q == 8'h00);
              if (!ir_q[9]) begin
                work_d = res_q;
              end
            end
            if (is_bz && taken_q) begin
              pc_d = pc_q + {{12{ir_q[7]}}, ir_q[7:0], 1'b0};
              st_d = ST_NOP;
            end
            if (is_call) begin
              if (pend_q) begin
                pc_d   = {slot_q[11:0], ir_q[7:0], 1'b0};
                pend_d = 1'b0;
                st_d   = ST_NOP;
              end else begin
                st_d = ST_EXEC;
              end
            end
          end
          default: st_d = ST_IDLE;
        endcase
      end
      ST_NOP: begin
        if (last) begin
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase

    // a write landing as the slot is consumed is kept, not lost
    if (wr_en && (i_paddr == REG_INSTR) && pend_q && !pend_d) begin
      slot_d = i_pwdata[15:0];
      pend_d = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st_q        <= ST_IDLE;
      pend_q      <= 1'b0;
      slot_q      <= 16'h0000;
      ir_q        <= 16'h0000;
      pc_q        <= PC_RST;
      tos_q       <= PC_RST;
      work_q      <= BYTE_RST;
      flags_q     <= FLAGS_RST;
      bank_q      <= BANK_RST;
      work_shd_q  <= BYTE_RST;
      flags_shd_q <= FLAGS_RST;
      bank_shd_q  <= BANK_RST;
      ext_en_q    <= 1'b0;
      index_q     <= INDEX_RST;
      opnd_q      <= BYTE_RST;
      res_q       <= BYTE_RST;
      taken_q     <= 1'b0;
      wdt_q       <= BYTE_RST;
      post_q      <= BYTE_RST;
      to_n_q      <= 1'b1;
      pd_n_q      <= 1'b1;
      daddr_q     <= 12'h000;
      dwe_q       <= 1'b0;
      dwdata_q    <= BYTE_RST;
      prdata_q    <= 32'h00000000;
      pready_q    <= 1'b0;
      pslverr_q   <= 1'b0;
    end else begin
      st_q        <= st_d;
      pend_q      <= pend_d;
      slot_q      <= slot_d;
      ir_q        <= ir_d;
      pc_q        <= pc_d;
      tos_q       <= tos_d;
      work_q      <= work_d;
      flags_q     <= flags_d;
      bank_q      <= bank_d;
      work_shd_q  <= work_shd_d;
      flags_shd_q <= flags_shd_d;
      bank_shd_q  <= bank_shd_d;
      ext_en_q    <= ext_en_d;
      index_q     <= index_d;
      opnd_q      <= opnd_d;
      res_q       <= res_d;
      taken_q     <= taken_d;
      wdt_q       <= wdt_d;
      post_q      <= post_d;
      to_n_q      <= to_n_d;
      pd_n_q      <= pd_n_d;
      daddr_q     <= daddr_d;
      dwe_q       <= dwe_d;
      dwdata_q    <= dwdata_d;
      prdata_q    <= prdata_d;
      pready_q    <= pready_d;
      pslverr_q   <= pslverr_d;
    end
  end

  assign o_prdata     = prdata_q;
  assign o_pready     = pready_q;
  assign o_pslverr    = pslverr_q;
  assign o_dmem_addr  = daddr_q;
  assign o_dmem_we    = dwe_q;
  assign o_dmem_wdata = dwdata_q;

endmodule : cxe_core

// *** cxe_pkg.sv ***
// constants, types and register map of the instruction execution block
// assumes a single 100 mhz clock and apb register access
package cxe_pkg;

  localparam int PC_W    = 21;
  localparam int DADDR_W = 12;
  localparam int STAT_W  = 5;

  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} cxe_phase_t;
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_NOP} cxe_state_t;

  // opcode fields, matched against the top bits of the instruction word
  localparam logic [7:0]  OP_BZ     = 8'he0;   // word[15:8]
  localparam logic [6:0]  OP_CALL   = 7'h76;   // word[15:9], s in word[8]
  localparam logic [6:0]  OP_CLEAR_FILE_OP   = 7'h35;   // word[15:9], a in word[8]
  localparam logic [5:0]  OP_COMPLEMENT_FILE_OP   = 6'h07;   // word[15:10], d, a
  localparam logic [15:0] OP_CLEAR_WATCHDOG_OP = 16'h0004;

  // apb register byte offsets
  localparam logic [7:0] REG_INSTR  = 8'h00;
  localparam logic [7:0] REG_CTRL   = 8'h04;
  localparam logic [7:0] REG_PC     = 8'h08;
  localparam logic [7:0] REG_WORK   = 8'h0c;
  localparam logic [7:0] REG_FLAGS  = 8'h10;
  localparam logic [7:0] REG_CORE   = 8'h14;
  localparam logic [7:0] REG_BANK   = 8'h18;
  localparam logic [7:0] REG_SHADOW = 8'h1c;
  localparam logic [7:0] REG_STACK  = 8'h20;
  localparam logic [7:0] REG_WDOG   = 8'h24;
  localparam logic [7:0] REG_INDEX  = 8'h28;

  // field positions
  localparam int FLG_C_BIT   = 0;
  localparam int FLG_DC_BIT  = 1;
  localparam int FLG_Z_BIT   = 2;
  localparam int FLG_OV_BIT  = 3;
  localparam int FLG_N_BIT   = 4;
  localparam int CTRL_EXT_BIT = 0;
  localparam int CORE_BUSY_BIT = 0;
  localparam int CORE_PEND_BIT = 1;
  localparam int CORE_TO_BIT   = 2;
  localparam int CORE_PD_BIT   = 3;
  localparam int SHD_STAT_LSB  = 8;
  localparam int SHD_BANK_LSB  = 16;
  localparam int WDOG_POST_LSB = 8;

  // access bank split and indexed window
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [7:0] INDEXED_MAX  = 8'h5f;
  localparam logic [3:0] ACCESS_HIGH  = 4'hf;

  // reset values
  localparam logic [PC_W-1:0]   PC_RST    = 21'h000000;
  localparam logic [7:0]        BYTE_RST  = 8'h00;
  localparam logic [STAT_W-1:0] FLAGS_RST = 5'h00;
  localparam logic [3:0]        BANK_RST  = 4'h0;
  localparam logic [11:0]       INDEX_RST = 12'h000;

endpackage : cxe_pkg

// *** cxe_phase_gen.sv ***
// four-phase instruction cycle sequencer
// assumes i_run is low only while idle or stalled; the phase holds then
`timescale 1ns/1ns
module cxe_phase_gen (
  // clock and reset
  input  wire logic               i_ref_clk,
  input  wire logic               i_rst,
  // control
  input  wire logic               i_run,
  // phase
  output cxe_pkg::cxe_phase_t     o_phase,
  output logic                    o_last
);
  import cxe_pkg::*;

  cxe_phase_t phase_q;
  cxe_phase_t phase_d;

  always_comb begin
    // holding (not restarting) keeps a stalled call from redoing q1..q3
    phase_d = i_run ? cxe_phase_t'(phase_q + 2'h1) : phase_q;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      phase_q <= PH_Q1;
    end else begin
      phase_q <= phase_d;
    end
  end

  assign o_phase = phase_q;
  assign o_last  = i_run && (phase_q == PH_Q4);

endmodule : cxe_phase_gen

// *** cxe_addr_dec.sv ***
// file register address decode: access bank, banked or indexed
// assumes purely combinational use inside the core
`timescale 1ns/1ns
module cxe_addr_dec (
  // operand fields
  input  wire logic        i_use_bank,
  input  wire logic [7:0]  i_fsel,
  // core state
  input  wire logic [3:0]  i_bank,
  input  wire logic        i_ext_en,
  input  wire logic [11:0] i_index_base,
  // result
  output logic [11:0]      o_addr,
  output logic             o_indexed
);
  import cxe_pkg::*;

  always_comb begin
    o_indexed = !i_use_bank && i_ext_en && (i_fsel <= INDEXED_MAX);
    if (o_indexed) begin
      o_addr = i_index_base + {4'h0, i_fsel};
    end else if (i_use_bank) begin
      o_addr = {i_bank, i_fsel};
    end else if (i_fsel < ACCESS_SPLIT) begin
      o_addr = {4'h0, i_fsel};
    end else begin
      o_addr = {ACCESS_HIGH, i_fsel};
    end
  end

endmodule : cxe_addr_dec

// *** cxe_core_asserts.sv ***
// checker for the bus and data memory ports of the execution core
// assumes binding to cxe_core, one clock, synchronous active-high reset
`timescale 1ns/1ns
module cxe_core_chk (
  // clock and reset
  input  wire logic                         i_ref_clk,
  input  wire logic                         i_rst,
  // apb
  input  wire logic                         i_psel,
  input  wire logic                         i_penable,
  input  wire logic                         i_pwrite,
  input  wire logic [7:0]                   i_paddr,
  input  wire logic [31:0]                  i_pwdata,
  input  wire logic [31:0]                  o_prdata,
  input  wire logic                         o_pready,
  input  wire logic                         o_pslverr,
  // data memory
  input  wire logic [cxe_pkg::DADDR_W-1:0]  o_dmem_addr,
  input  wire logic                         o_dmem_we,
  input  wire logic [7:0]                   o_dmem_wdata,
  input  wire logic [7:0]                   i_dmem_rdata
);
  import cxe_pkg::*;
  logic unmapped;
  assign unmapped = (i_paddr[1:0] != 2'h0) || (i_paddr > REG_INDEX);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  a_ready_one_wait: assert property ($rose(i_penable) && i_psel
    |-> !o_pready ##1 o_pready) else $error("pready wait state wrong");
  a_ready_pulse: assert property (o_pready |=> !o_pready)
    else $error("pready longer than one cycle");
  a_ready_cause: assert property (o_pready |-> $past(i_psel && i_penable))
    else $error("pready without access phase");
  a_err_decode: assert property (o_pready |-> o_pslverr == unmapped)
    else $error("pslverr does not match address decode");
  a_err_ready: assert property (o_pslverr |-> o_pready)
    else $error("pslverr outside pready");
  a_err_rdata: assert property (o_pready && o_pslverr && !i_pwrite
    |-> o_prdata == 32'h0) else $error("error read data not zero");
  a_we_pulse: assert property ($rose(o_dmem_we) |=> !o_dmem_we)
    else $error("write enable longer than one clock");
  a_addr_hold: assert property (o_dmem_we |-> $stable(o_dmem_addr))
    else $error("memory address moved before write");
  a_wdata_value: assert property (o_dmem_we |->
    (o_dmem_wdata == 8'h00 || o_dmem_wdata == ~$past(i_dmem_rdata)))
    else $error("memory write data neither zero nor complement");

  c_err: cover property (o_pready && o_pslverr);
  c_clear: cover property (o_dmem_we && o_dmem_wdata == 8'h00);
  c_issue: cover property (o_pready && i_pwrite && i_paddr == REG_INSTR);
endmodule : cxe_core_chk

bind cxe_core cxe_core_chk cxe_core_chk_i (.i_ref_clk, .i_rst, .i_psel,
  .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready,
  .o_pslverr, .o_dmem_addr, .o_dmem_we, .o_dmem_wdata, .i_dmem_rdata);

// *** cxe_core_tb.sv ***
// self-checking bench for the execution core, driven over apb
// assumes cxe_pkg compiled first; data memory is modelled here
`timescale 1ns/1ns
module cxe_core_tb;
  import cxe_pkg::*;
  typedef struct {string nm; logic [31:0] exp, msk; logic err;} cxe_note_t;
  localparam logic [31:0] ALL = 32'hffffffff;
  localparam logic [10:0] COMPLEMENT_FILE_OP_SET [6] = '{11'h280, 11'h25f, 11'h133,
                                           11'h65f, 11'h660, 11'h400};
  logic        i_ref_clk, i_rst, i_psel, i_penable, i_pwrite;
  logic [7:0]  i_paddr, o_dmem_wdata, i_dmem_rdata, rnd, r;
  logic [31:0] i_pwdata, o_prdata, rd;
  logic        o_pready, o_pslverr, o_dmem_we;
  logic [11:0] o_dmem_addr, ad;
  logic [7:0]  mem [0:4095];
  cxe_note_t   notes [$];
  cxe_note_t   nt;
  logic [19:0] wnotes [$];
  logic [19:0] wn, k;
  logic [10:0] c;
  logic [3:0]  b;
  logic [20:0] pc;
  int          n_fail, total_checks;

  cxe_core cxe_core_i (.i_ref_clk, .i_rst, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .o_dmem_addr,
    .o_dmem_we, .o_dmem_wdata, .i_dmem_rdata);

  always #5 i_ref_clk = ~i_ref_clk;
  assign i_dmem_rdata = mem[o_dmem_addr];

  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : lfsr

  function automatic logic [11:0] fadr(input logic e, a, input logic [7:0] f);
    if (a) return {b, f};
    if (e && f <= INDEXED_MAX) return 12'h100 + {4'h0, f};
    return (f < ACCESS_SPLIT) ? {4'h0, f} : {ACCESS_HIGH, f};
  endfunction : fadr

  task automatic cmp(input string nm, input logic [31:0] e, s);
    total_checks++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge i_ref_clk);
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= wd;
    @(posedge i_ref_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_ref_clk);
    end while (o_pready !== 1'b1);
    rd = o_prdata;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] e, m);
    notes.push_back('{nm, e, m, (a[1:0] != 2'h0) || (a > REG_INDEX)});
    apb(1'b0, a, 32'h0);
  endtask : rdc

  // issue one word, then poll until neither busy nor pending
  task automatic run(input logic [15:0] w);
    wr(REG_INSTR, {16'h0, w});
    do begin
      rdc("core poll", REG_CORE, 32'h0, 32'h0);
    end while (rd[1:0] !== 2'b00);
  endtask : run

  always @(posedge i_ref_clk) begin
    if (o_dmem_we === 1'b1) begin
      mem[o_dmem_addr] <= o_dmem_wdata;
      wn = (wnotes.size() > 0) ? wnotes.pop_front() : 20'hfffff;
      cmp("dmem write", {12'h0, wn}, {12'h0, o_dmem_addr, o_dmem_wdata});
    end
    if (o_pready === 1'b1 && i_psel && i_penable && !i_pwrite &&
        notes.size() > 0) begin
      nt = notes.pop_front();
      cmp(nt.nm, nt.exp & nt.msk, o_prdata & nt.msk);
      cmp("pslverr", {31'h0, nt.err}, {31'h0, o_pslverr});
    end
  end

  initial begin
    #900000;
    n_fail++;
    close_out();
  end

  initial begin
    {i_ref_clk, i_psel, i_penable, i_pwrite} = 4'h0;
    i_rst = 1'b1;
    i_paddr = 8'h00;
    i_pwdata = 32'h0;
    {n_fail, total_checks} = {32'h0, 32'h0};
    rnd = 8'h23;
    b = 4'h0;
    for (int i = 0; i < 4096; i++) mem[i] = i[7:0] ^ 8'ha5;
    mem[12'hf60] = 8'hff;
    repeat (16) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    rdc("pc", REG_PC, 32'h0, ALL);
    rdc("flags", REG_FLAGS, 32'h0, ALL);
    rdc("core", REG_CORE, 32'hc, ALL);
    rdc("shadow", REG_SHADOW, 32'h0, ALL);
    rdc("unmapped", 8'h3c, 32'h0, ALL);
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      b = rnd[3:0];
      rnd = lfsr(rnd);
      wr(REG_BANK, {28'h0, b});
      wr(REG_FLAGS, 32'h0);
      wnotes.push_back({b, rnd, 8'h00});
      run({OP_CLEAR_FILE_OP, 1'b1, rnd});
      rdc("zero flag", REG_FLAGS, 32'h4, 32'h4);
    end
    wr(REG_INDEX, 32'h100);
    for (int i = 0; i < 6; i++) begin
      c = COMPLEMENT_FILE_OP_SET[i];
      ad = fadr(c[10], c[8], c[7:0]);
      r = ~mem[ad];
      wr(REG_CTRL, {31'h0, c[10]});
      if (c[9]) wnotes.push_back({ad, r});
      run({OP_COMPLEMENT_FILE_OP, c[9:8], c[7:0]});
      if (!c[9]) rdc("work", REG_WORK, {24'h0, r}, ALL);
      rdc("nz", REG_FLAGS, {27'h0, r[7], 1'b0, r == 8'h0, 2'h0}, 32'h14);
    end
    pc = 21'h1000;
    wr(REG_PC, {11'h0, pc});
    for (int i = 0; i < 3; i++) begin
      c = (i == 0) ? 11'h180 : (i == 1) ? 11'h07f : 11'h17f;
      wr(REG_FLAGS, {29'h0, c[8], 2'h0});
      run({OP_BZ, c[7:0]});
      pc = pc + 21'h2 + (c[8] ? {{12{c[7]}}, c[7:0], 1'b0} : 21'h0);
      rdc("branch pc", REG_PC, {11'h0, pc}, ALL);
    end
    wr(REG_WORK, 32'h3c);
    wr(REG_FLAGS, 32'h15);
    wr(REG_BANK, 32'h9);
    wr(REG_PC, 32'h2000);
    for (int i = 0; i < 2; i++) begin
      rnd = lfsr(rnd);
      k = {4'h5, rnd, ~rnd};
      pc = (i == 0) ? 21'h2000 : pc;
      wr(REG_INSTR, {16'h0, OP_CALL, i == 0, k[7:0]});
      run({4'h0, k[19:8]});
      rdc("call pc", REG_PC, {11'h0, k, 1'b0}, ALL);
      rdc("stack", REG_STACK, {11'h0, pc + 21'h4}, ALL);
      rdc("shadow", REG_SHADOW, 32'h0009153c, ALL);
      pc = {k, 1'b0};
      wr(REG_WORK, 32'h11);
    end
    // let the watchdog wrap so that the clear has a flag to set again
    repeat (65536) @(posedge i_ref_clk);
    rdc("timeout", REG_CORE, 32'h0, 32'h4);
    run(OP_CLEAR_WATCHDOG_OP);
    rdc("wdog", REG_WDOG, 32'h0, 32'hc0ff);
    rdc("core", REG_CORE, 32'hc, 32'hf);
    repeat (2) @(posedge i_ref_clk);
    cmp("open dmem notes", 32'h0, wnotes.size());
    close_out();
  end
endmodule : cxe_core_tb
